// ==== verilog/irq_pending_threshold_cfg_consts.svh ====
// Constants for the pending/threshold/keyed-config block
`ifndef IRQ_PENDING_THRESHOLD_CFG_CONSTS_SVH
`define IRQ_PENDING_THRESHOLD_CFG_CONSTS_SVH
`define OFF_PEND_LOW 8'h20
`define OFF_PEND_HIGH 8'h24
`define OFF_THRESH 8'h40
`define OFF_CFG 8'h48
`define OFF_CTRL_WORD 8'h50
`define OFF_EVT_STAT 8'h54
`define OFF_EVT_MASK 8'h58
`define PEND_LOW_MASK 32'hffff500c
`define PEND_HIGH_MASK 32'h0000007f
`define THRESH_KEEP_MASK 8'hc0
`define KEY_FIRST 16'hfa05
`define KEY_SECOND 16'hbcaf
`define KEY_RESET 16'hbeef
`define CFG_KEY_LSB 16
`define CFG_RESET_BIT 7
`define CTRL_RESET_BIT 31
`define NMI_NUM 2
`define EXC_NUM 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define EVT_RESET 0
`define EVT_BADKEY 1
`define EVT_COUNT 2
`define NUM_IRQ 39
`define FIRST_IRQ 2
`define THRESH_OFF 8'h00
`endif

// ==== verilog/irq_types_pkg.sv ====
// Types shared by the block and its bus slave
package irq_types_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01
    } chan_state_type;
endpackage : irq_types_pkg

// ==== verilog/reg_access_if.sv ====
// Decoded register access between the bus slave and the block core
interface reg_access_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                   input wr_err, rd_data, rd_err);
    modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : reg_access_if

// ==== verilog/axil_slave.sv ====
// AXI4-Lite slave turning bus handshakes into single-cycle register accesses
`include "irq_pending_threshold_cfg_consts.svh"
module axil_slave (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    reg_access_if.slave ra
);
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        irq_types_pkg::chan_state_type wst;
        logic [1:0] bresp;
        irq_types_pkg::chan_state_type rst;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
        logic b_vld;
        logic r_vld;
    } slave_state_type;

    slave_state_type s_q, s_d;
    logic do_wr, do_rd;

    // Address and data may arrive in either order; each is held until both exist
    assign awready_o = s_q.aw_rdy;
    assign wready_o = s_q.w_rdy;
    assign arready_o = s_q.ar_rdy;
    assign bvalid_o = s_q.b_vld;
    assign bresp_o = s_q.bresp;
    assign rvalid_o = s_q.r_vld;
    assign rdata_o = s_q.rdata;
    assign rresp_o = s_q.rresp;

    assign do_wr = s_q.aw_have && s_q.w_have && (s_q.wst == irq_types_pkg::ST_IDLE);
    assign do_rd = arvalid_i && arready_o;
    assign ra.wr_en = do_wr;
    assign ra.wr_addr = s_q.aw_addr;
    assign ra.wr_data = s_q.w_data;
    assign ra.wr_strb = s_q.w_strb;
    assign ra.rd_en = do_rd;
    assign ra.rd_addr = araddr_i;

    always_comb begin
        s_d = s_q;
        if (awvalid_i && awready_o) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            s_d.w_have = 1'b1;
            s_d.w_data = wdata_i;
            s_d.w_strb = wstrb_i;
        end
        case (s_q.wst)
            irq_types_pkg::ST_IDLE: begin
                if (do_wr) begin
                    s_d.aw_have = 1'b0;
                    s_d.w_have = 1'b0;
                    s_d.bresp = ra.wr_err ? `RESP_SLVERR : `RESP_OKAY;
                    s_d.wst = irq_types_pkg::ST_RESP;
                end
            end
            irq_types_pkg::ST_RESP: begin
                if (bready_i) begin
                    s_d.wst = irq_types_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.wst = irq_types_pkg::ST_IDLE;
            end
        endcase
        case (s_q.rst)
            irq_types_pkg::ST_IDLE: begin
                if (do_rd) begin
                    s_d.rdata = ra.rd_data;
                    s_d.rresp = ra.rd_err ? `RESP_SLVERR : `RESP_OKAY;
                    s_d.rst = irq_types_pkg::ST_RESP;
                end
            end
            irq_types_pkg::ST_RESP: begin
                if (rready_i) begin
                    s_d.rst = irq_types_pkg::ST_IDLE;
                end
            end
            default: begin
                s_d.rst = irq_types_pkg::ST_IDLE;
            end
        endcase
        // Handshake pins are stored from the next state so they leave flops directly
        s_d.aw_rdy = ~s_d.aw_have && (s_d.wst == irq_types_pkg::ST_IDLE);
        s_d.w_rdy = ~s_d.w_have && (s_d.wst == irq_types_pkg::ST_IDLE);
        s_d.ar_rdy = (s_d.rst == irq_types_pkg::ST_IDLE);
        s_d.b_vld = (s_d.wst == irq_types_pkg::ST_RESP);
        s_d.r_vld = (s_d.rst == irq_types_pkg::ST_RESP);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.aw_rdy <= 1'b1;
            s_q.w_rdy <= 1'b1;
            s_q.ar_rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : axil_slave

// ==== verilog/irq_pending_threshold_cfg.sv ====
// Pending status, priority threshold and keyed reset-request block
// What this block does
// - Low pending word shows interrupts 2,3,12,14,16-31
// - High pending word shows 32-38, rest zero
// - Priority below threshold gets no service
// - Zero threshold disables filtering entirely
// - Only threshold bits 7:6 store; others zero
// - Key field write-only, always reads zero
// - Three distinct 16-bit keys are recognised
// - Bit 7 with reset key requests reset
// - Control word bit 31 requests reset, no key needed
// - NMI and exception pending settable and clearable
//
// Local design decision: register access over AXI4-Lite.
`include "irq_pending_threshold_cfg_consts.svh"
module irq_pending_threshold_cfg (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic [38:0] pending_flag_set_i,
    input wire logic [38:0] pending_flag_clr_i,
    input wire logic [38:0][7:0] irq_priority_i,
    output logic [38:0] eligible_o,
    output logic sys_reset_req_o,
    output logic first_key_seen_o,
    output logic second_key_seen_o,
    output logic irq_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [38:0] pending;
        logic [7:0] thresh;
        logic [38:0] eligible;
        logic reset_req;
        logic first_seen;
        logic second_seen;
        logic [1:0] evt_stat;
        logic [1:0] evt_mask;
        logic irq;
    } core_state_type;

    core_state_type c_q, c_d;
    reg_access_if ra ();

    logic [31:0] pend_low_view;
    logic [31:0] pend_high_view;
    logic [31:0] thresh_view;
    logic [31:0] evt_stat_view;
    logic [31:0] evt_mask_view;
    logic [38:0] pend_next;
    logic [38:0] elig_next;
    logic [15:0] wkey;
    logic reset_bit;
    logic key_first_hit;
    logic key_second_hit;
    logic key_reset_hit;
    logic thresh_wr;
    logic cfg_wr;
    logic ctrl_wr;
    logic stat_wr;
    logic mask_wr;
    logic req_cfg;
    logic req_ctrl;
    logic bad_key;
    logic [1:0] evt_set;
    logic [1:0] evt_next;

    axil_slave u_slave (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .awaddr_i(awaddr_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .bresp_o(bresp_o),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .araddr_i(araddr_i),
        .arvalid_i(arvalid_i),
        .arready_o(arready_o),
        .rdata_o(rdata_o),
        .rresp_o(rresp_o),
        .rvalid_o(rvalid_o),
        .rready_i(rready_i),
        .ra(ra)
    );

    // ************************************************************
    // Status views
    // ************************************************************
    // low word layout
    assign pend_low_view = {c_q.pending[31:0]} & `PEND_LOW_MASK;
    assign pend_high_view = {25'h0000000, c_q.pending[38:32]} & `PEND_HIGH_MASK;

    assign thresh_view = {24'h000000, c_q.thresh};
    assign evt_stat_view = {30'h00000000, c_q.evt_stat};
    assign evt_mask_view = {30'h00000000, c_q.evt_mask};

    // ************************************************************
    // Write decode
    // ************************************************************
    assign wkey = ra.wr_data[31:`CFG_KEY_LSB];
    assign reset_bit = ra.wr_data[`CFG_RESET_BIT];
    assign key_first_hit = (wkey == `KEY_FIRST);
    assign key_second_hit = (wkey == `KEY_SECOND);
    assign key_reset_hit = (wkey == `KEY_RESET);
    // Strobe honoured only on the byte that holds the threshold
    assign thresh_wr = ra.wr_en && (ra.wr_addr == `OFF_THRESH) && ra.wr_strb[0];
    assign cfg_wr = ra.wr_en && (ra.wr_addr == `OFF_CFG);
    assign ctrl_wr = ra.wr_en && (ra.wr_addr == `OFF_CTRL_WORD);
    assign stat_wr = ra.wr_en && (ra.wr_addr == `OFF_EVT_STAT);
    assign mask_wr = ra.wr_en && (ra.wr_addr == `OFF_EVT_MASK);
    assign req_cfg = cfg_wr && reset_bit && key_reset_hit;
    assign req_ctrl = ctrl_wr && ra.wr_data[`CTRL_RESET_BIT];
    assign bad_key = cfg_wr && reset_bit && !key_reset_hit;

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        ra.rd_data = 32'h00000000;
        ra.rd_err = 1'b0;
        case (ra.rd_addr)
            `OFF_PEND_LOW: begin
                ra.rd_data = pend_low_view;
            end
            `OFF_PEND_HIGH: begin
                ra.rd_data = pend_high_view;
            end
            `OFF_THRESH: begin
                ra.rd_data = thresh_view;
            end
            `OFF_CFG: begin
                ra.rd_data = 32'h00000000;
            end
            `OFF_CTRL_WORD: begin
                ra.rd_data = 32'h00000000;
            end
            `OFF_EVT_STAT: begin
                ra.rd_data = evt_stat_view;
            end
            `OFF_EVT_MASK: begin
                ra.rd_data = evt_mask_view;
            end
            default: begin
                ra.rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        case (ra.wr_addr)
            `OFF_PEND_LOW, `OFF_PEND_HIGH, `OFF_THRESH, `OFF_CFG, `OFF_CTRL_WORD,
            `OFF_EVT_STAT, `OFF_EVT_MASK: begin
                ra.wr_err = 1'b0;
            end
            default: begin
                ra.wr_err = 1'b1;
            end
        endcase
    end

    // ************************************************************
    // Per-interrupt pending and eligibility
    // ************************************************************
    for (genvar g = 0; g < `NUM_IRQ; g++) begin : g_irq
        if (g < `FIRST_IRQ) begin : g_none
            // Numbers below two do not exist, so they never pend
            assign pend_next[g] = 1'b0;
            assign elig_next[g] = 1'b0;
        end else begin : g_live
            // NMI and exception pend like others, set wins
            assign pend_next[g] = (c_q.pending[g] & ~pending_flag_clr_i[g]) |
                pending_flag_set_i[g];
            assign elig_next[g] = c_q.pending[g] &&
                ((c_q.thresh == `THRESH_OFF) || (irq_priority_i[g] >= c_q.thresh));
        end
    end

    // ************************************************************
    // Event flags
    // ************************************************************
    assign evt_set[`EVT_RESET] = req_cfg || req_ctrl;
    assign evt_set[`EVT_BADKEY] = bad_key;
    for (genvar e = 0; e < `EVT_COUNT; e++) begin : g_evt
        // Set wins over a write-one clear in the same cycle
        assign evt_next[e] = evt_set[e] ||
            (c_q.evt_stat[e] && !(stat_wr && ra.wr_data[e]));
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        c_d = c_q;
        c_d.pending = pend_next;
        c_d.eligible = elig_next;
        if (thresh_wr) begin
            c_d.thresh = ra.wr_data[7:0] & `THRESH_KEEP_MASK;
        end
        c_d.reset_req = req_cfg || req_ctrl;
        c_d.first_seen = cfg_wr && key_first_hit;
        c_d.second_seen = cfg_wr && key_second_hit;
        if (mask_wr) begin
            c_d.evt_mask = ra.wr_data[1:0];
        end
        c_d.evt_stat = evt_next;
        // Built from the next flags so the level moves in the same cycle as them
        c_d.irq = |(evt_next & c_d.evt_mask);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign eligible_o = c_q.eligible;
    assign sys_reset_req_o = c_q.reset_req;
    assign first_key_seen_o = c_q.first_seen;
    assign second_key_seen_o = c_q.second_seen;
    assign irq_o = c_q.irq;
endmodule : irq_pending_threshold_cfg

// ==== verification/irq_pending_threshold_cfg_monitor.sv ====
// Checker for the pending, threshold and keyed reset block
module irq_cfg_monitor (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic bvalid_o,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    input wire logic arready_o,
    input wire logic [31:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic sys_reset_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Properties
    // ****
    logic [7:0] aw_q, ar_q;
    logic [31:0] w_q;
    // Last taken access explains each answer and reset pulse
    always_ff @(posedge clk_i) begin
        if (awvalid_i && awready_o) aw_q <= awaddr_i;
        if (wvalid_i && wready_o) w_q <= wdata_i;
        if (arvalid_i && arready_o) ar_q <= araddr_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_wr; awvalid_i && awready_o && wvalid_i && wready_o; endsequence
    sequence s_rd; arvalid_i && arready_o; endsequence
    property p_blat; s_wr |-> ##2 bvalid_o; endproperty
    a_blat: assert property (p_blat) else $error("late write response");
    property p_rlat; s_rd |=> rvalid_o; endproperty
    a_rlat: assert property (p_rlat) else $error("late read data");
    property p_pulse; sys_reset_req_o |=> !sys_reset_req_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset request too long");
    property p_cause;
        sys_reset_req_o |-> (aw_q == 8'h48 && w_q[31:16] == 16'hbeef && w_q[7])
            || (aw_q == 8'h50 && w_q[31]);
    endproperty
    a_cause: assert property (p_cause) else $error("reset without cause");
    property p_low; rvalid_o && ar_q == 8'h20 |-> (rdata_o & 32'h0000aff3) == 32'h0; endproperty
    a_low: assert property (p_low) else $error("low pending reserved set");
    property p_high; rvalid_o && ar_q == 8'h24 |-> rdata_o[31:7] == 25'h0; endproperty
    a_high: assert property (p_high) else $error("high pending reserved set");
    property p_thr;
        rvalid_o && ar_q == 8'h40 |-> rdata_o[31:8] == 24'h0 && rdata_o[5:0] == 6'h0;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold low bits set");
    property p_key; rvalid_o && ar_q == 8'h48 |-> rdata_o[31:16] == 16'h0; endproperty
    a_key: assert property (p_key) else $error("key field readable");
endmodule : irq_cfg_monitor
bind irq_pending_threshold_cfg irq_cfg_monitor monitor_i (.*);

// ==== verification/irq_source_model.sv ====
// Interrupt sources and priority values facing the block
module irq_source_model (
    input wire logic clk_i,
    output logic [38:0] set_o,
    output logic [38:0] clr_o,
    output logic [38:0][7:0] prio_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Sources
    // ****
    initial set_o = '0;
    initial clr_o = '0;
    // Priority rises by six per number so thresholds split the range
    always_comb for (int i = 0; i < 39; i++) prio_o[i] = 8'(i * 6);
    task automatic pulse(input logic [38:0] s, input logic [38:0] c);
        @(posedge clk_i);
        set_o <= s;
        clr_o <= c;
        @(posedge clk_i);
        set_o <= '0;
        clr_o <= '0;
    endtask : pulse
endmodule : irq_source_model

// ==== verification/irq_pending_threshold_cfg_tb.sv ====
// Self-checking bench for the pending, threshold and keyed reset block
module irq_pending_threshold_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Bench
    // ****
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic awvalid_i = 1'b0;
    logic wvalid_i = 1'b0;
    logic bready_i = 1'b0;
    logic arvalid_i = 1'b0;
    logic rready_i = 1'b0;
    logic [7:0] awaddr_i = 8'h0;
    logic [7:0] araddr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [3:0] wstrb_i = 4'hf;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
    logic sys_reset_req_o, first_key_seen_o, second_key_seen_o;
    logic [1:0] bresp_o, rresp_o;
    logic [31:0] rdata_o, v;
    logic [38:0] set_w, clr_w, eligible_o;
    logic [38:0][7:0] prio_w;
    int mismatches = 0, total_checks = 0, n_rst = 0, n_k1 = 0, n_k2 = 0;
    always #20 clk_i = ~clk_i;
    // Pulses last one cycle, so they are counted rather than sampled
    always @(posedge clk_i) begin
        n_rst <= n_rst + int'(sys_reset_req_o);
        n_k1 <= n_k1 + int'(first_key_seen_o);
        n_k2 <= n_k2 + int'(second_key_seen_o);
    end
    irq_pending_threshold_cfg irq_pending_threshold_cfg_i (.*,
        .pending_flag_set_i(set_w), .pending_flag_clr_i(clr_w), .irq_priority_i(prio_w));
    irq_source_model irq_source_model_i (.clk_i, .set_o(set_w), .clr_o(clr_w), .prio_o(prio_w));
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk_i);
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready_o) awvalid_i <= 1'b0;
            if (wready_o) wvalid_i <= 1'b0;
        end while (bvalid_o !== 1'b1);
        bready_i <= 1'b0;
        chk("bresp", 64'(bresp_o), 64'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] er = 2'h0);
        @(posedge clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready_o) arvalid_i <= 1'b0;
        end while (rvalid_o !== 1'b1);
        rready_i <= 1'b0;
        v = rdata_o;
        chk("rresp", 64'(rresp_o), 64'(er));
    endtask : rd
    task automatic t_pending();
        irq_source_model_i.pulse({39{1'b1}}, 39'h0);
        rd(8'h20);
        chk("pend_low", v, 32'hffff500c);
        rd(8'h24);
        chk("pend_high", v, 32'h7f);
        irq_source_model_i.pulse(39'h0, 39'h1000c);
        rd(8'h20);
        chk("pend_clr", v, 32'hfffe5000);
        irq_source_model_i.pulse(39'h1000c, 39'h4);
        rd(8'h20);
        chk("pend_set", v, 32'hffff500c);
    endtask : t_pending
    task automatic t_threshold();
        logic [7:0] tv [3] = '{8'h7f, 8'hff, 8'h00};
        logic [38:0] e;
        for (int k = 0; k < 3; k++) begin
            wr(8'h40, {24'hffffff, tv[k]});
            rd(8'h40);
            chk("thresh", v, {24'h0, tv[k] & 8'hc0});
            for (int i = 0; i < 39; i++) e[i] = tv[k] < 8'h40 || i * 6 >= int'(tv[k] & 8'hc0);
            chk("eligible", eligible_o & 39'h7fffff500c, e & 39'h7fffff500c);
        end
        // A cleared strobe must leave the stored threshold alone
        wstrb_i <= 4'h0;
        wr(8'h40, 32'h000000c0);
        wstrb_i <= 4'hf;
        rd(8'h40);
        chk("thresh_strb", v, 32'h0);
    endtask : t_threshold
    task automatic t_keys();
        wr(8'h48, 32'hfa050080);
        wr(8'h48, 32'hbcaf0080);
        wr(8'h48, 32'hbeef0000);
        rd(8'h48);
        chk("first_key_seen", n_k1, 1);
        chk("second_key_seen", n_k2, 1);
        chk("no_reset", n_rst, 0);
        wr(8'h48, 32'hbeef0080);
        rd(8'h48);
        chk("cfg_read", v, 0);
        chk("reset_cfg", n_rst, 1);
        wr(8'h50, 32'h80000000);
        rd(8'h54);
        chk("evt_stat", v, 3);
        chk("reset_ctrl", n_rst, 2);
    endtask : t_keys
    task automatic t_events();
        chk("irq_masked", irq_o, 0);
        wr(8'h58, 32'h3);
        rd(8'h58);
        chk("irq_on", irq_o, 1);
        wr(8'h54, 32'h1);
        rd(8'h54);
        chk("stat_w1c", v, 2);
        wr(8'h58, 32'h1);
        rd(8'h30, 2'h2);
        chk("irq_off", irq_o, 0);
        wr(8'h30, 32'h1, 2'h2);
        wr(8'h48, 32'hbeef0080);
        rd(8'h54);
        chk("irq_reset_evt", irq_o, 1);
    endtask : t_events
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_pending();
        t_threshold();
        t_keys();
        t_events();
        print_verdict();
    end
    // A stuck handshake would otherwise hang the run
    initial begin
        repeat (4000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule : irq_pending_threshold_cfg_tb
